// ==== event_queue_producer_index.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - on overflow, invert flag bit 31 only when it equals the acknowledge flag.
// - after toggling, flag holds until software makes acknowledge equal.
// - overflow only when a record is dropped with queue enabled and full.
// - records dropped while queue disabled never touch the overflow flag.
// - stall records are never dropped; they wait, so never overflow.
// - write field split at queue size: that bit is wrap, lower bits index.
// - write index always names the next slot to be filled.
// - bits above the wrap flag read as zero when size below 19.
// - increment wraps at current size, toggling wrap flag on rollover.
// - size zero gives one entry; wrap flag sits at bit zero.
// - size growth leaves upper bits undefined; shrink truncates stored value.
// - producer flag and index have no architected reset value.
// - producer writable only while enable and its acknowledge are both zero.
module event_queue_producer_index (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic                            pready,
  output logic      [31:0]                prdata,
  output logic                            pslverr,
  input  wire logic                       ev_valid,
  output logic                            ev_ready,
  input  wire logic [evq_pkg::rec_w-1:0]  ev_data,
  input  wire logic                       ev_stall,
  output logic                            mem_wr_valid,
  input  wire logic                       mem_wr_ready,
  output logic      [evq_pkg::idx_w-2:0]  mem_wr_index,
  output logic      [evq_pkg::rec_w-1:0]  mem_wr_data
);

  logic [evq_pkg::idx_w-1:0]  wr_ff;
  logic                       ovf_ff;
  logic [evq_pkg::idx_w-1:0]  rd_ff;
  logic                       ack_flag_ff;
  logic                       en_ff;
  logic                       en_ack_ff;
  logic [evq_pkg::qs_w-1:0]   qs_ff;
  logic [31:0]                prdata_ff;
  logic                       pslverr_ff;
  evq_pkg::wr_state_e         st_ff;
  evq_pkg::wr_state_e         nxt_st;
  logic [evq_pkg::idx_w-2:0]  slot_ff;
  logic [evq_pkg::rec_w-1:0]  data_ff;

  // apb decode
  logic        setup;
  logic        wr_setup;
  logic        hit_prod;
  logic        hit_cons;
  logic        hit_ctrl;
  logic        hit_ack;
  logic        hit_any;
  logic        prod_wr_req;
  logic        prod_wr_en;
  logic [31:0] rd_mux;

  assign setup       = psel && !penable;
  assign wr_setup    = setup && pwrite;
  assign hit_prod    = (paddr == evq_pkg::prod_off);
  assign hit_cons    = (paddr == evq_pkg::cons_off);
  assign hit_ctrl    = (paddr == evq_pkg::ctrl_off);
  assign hit_ack     = (paddr == evq_pkg::ack_off);
  assign hit_any     = hit_prod || hit_cons || hit_ctrl || hit_ack;
  assign prod_wr_req = wr_setup && hit_prod;
  // guarded register: writes while enabled or not yet quiesced are ignored
  assign prod_wr_en  = prod_wr_req && !en_ff && !en_ack_ff;

  // size-derived masks; size clamps at the supported maximum
  logic [evq_pkg::qs_w-1:0]  qs_eff;
  logic [evq_pkg::idx_w:0]   one_hot;
  logic [evq_pkg::idx_w-1:0] wrap_sel;
  logic [evq_pkg::idx_w-1:0] field_mask;
  logic [evq_pkg::idx_w-1:0] idx_mask;
  logic [evq_pkg::idx_w-1:0] wr_eff;
  logic [evq_pkg::idx_w-1:0] diff;
  logic [evq_pkg::idx_w-1:0] wr_inc;
  logic                      q_full;
  logic                      q_empty;
  logic                      wrap_now;

  assign qs_eff     = (qs_ff > evq_pkg::qs_max) ? evq_pkg::qs_max : qs_ff;
  assign one_hot    = (evq_pkg::idx_w + 1)'(1) << qs_eff;
  assign wrap_sel   = one_hot[evq_pkg::idx_w-1:0];
  assign field_mask = wrap_sel | (wrap_sel - 1'b1);
  assign idx_mask   = wrap_sel - 1'b1;
  // shrinking the size simply truncates the stored value
  assign wr_eff     = wr_ff & field_mask;
  assign diff       = (wr_ff ^ rd_ff) & field_mask;
  assign q_full     = (diff == wrap_sel);
  assign q_empty    = (diff == '0);
  // carry out of the index field lands in the wrap bit
  assign wr_inc     = (wr_eff + 1'b1) & field_mask;
  assign wrap_now   = |(wr_ff & wrap_sel);

  assign rd_mux =
      hit_prod ? {ovf_ff, 11'h0, wr_eff} :
      hit_cons ? {ack_flag_ff, 11'h0, rd_ff} :
      hit_ctrl ? {19'h0, qs_ff, 7'h0, en_ff} :
      hit_ack  ? {28'h0, (ovf_ff != ack_flag_ff), q_empty, q_full, en_ack_ff} :
                 32'h0;

  // read data and error are captured in setup, so the access phase needs no wait
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff  <= pwrite ? 32'h0 : rd_mux;
      pslverr_ff <= !hit_any;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  // software registers; acknowledge stays up until an in-flight write lands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_ff       <= 1'b0;
      en_ack_ff   <= 1'b0;
      qs_ff       <= evq_pkg::qs_rst;
      rd_ff       <= evq_pkg::idx_rst;
      ack_flag_ff <= 1'b0;
    end else begin
      en_ack_ff <= en_ff || (en_ack_ff && (st_ff == evq_pkg::st_write));
      if (wr_setup && hit_ctrl) begin
        en_ff <= pwdata[evq_pkg::en_bit];
        qs_ff <= pwdata[evq_pkg::qs_lsb +: evq_pkg::qs_w];
      end
      if (wr_setup && hit_cons) begin
        rd_ff       <= pwdata[evq_pkg::idx_w-1:0];
        ack_flag_ff <= pwdata[evq_pkg::flag_bit];
      end
    end
  end

  // record path: events are buffered ahead of the queue writer
  logic                      fifo_out_valid;
  logic                      fifo_pop;
  logic [evq_pkg::rec_w:0]   fifo_out;
  logic                      rec_stall;
  logic                      blocked;
  logic                      drop_off;
  logic                      drop_full;
  logic                      accept;
  logic                      inc_fire;

  rec_fifo #(
    .WIDTH (evq_pkg::rec_w + 1),
    .DEPTH (evq_pkg::fifo_depth)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (ev_valid),
    .in_ready  (ev_ready),
    .in_data   ({ev_stall, ev_data}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  assign rec_stall = fifo_out[evq_pkg::rec_w];
  assign blocked   = !en_ff || q_full;
  // stall records wait in the fifo and back-pressure the source
  assign fifo_pop  = (st_ff == evq_pkg::st_idle) && fifo_out_valid
                     && !(rec_stall && blocked);
  assign drop_off  = fifo_pop && !en_ff;
  assign drop_full = fifo_pop && en_ff && q_full;
  assign accept    = fifo_pop && en_ff && !q_full;
  assign inc_fire  = (st_ff == evq_pkg::st_write) && mem_wr_ready;

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      evq_pkg::st_idle:  if (accept) nxt_st = evq_pkg::st_write;
      evq_pkg::st_write: if (mem_wr_ready) nxt_st = evq_pkg::st_idle;
      default:           nxt_st = evq_pkg::st_idle;
    endcase
  end

  // slot is the write index at the moment the record is taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff   <= evq_pkg::st_idle;
      slot_ff <= '0;
      data_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      if (accept) begin
        slot_ff <= wr_eff[evq_pkg::idx_w-2:0] & idx_mask[evq_pkg::idx_w-2:0];
        data_ff <= fifo_out[evq_pkg::rec_w-1:0];
      end
    end
  end

  assign mem_wr_valid = (st_ff == evq_pkg::st_write);
  assign mem_wr_index = slot_ff;
  assign mem_wr_data  = data_ff;

  // producer register; reset value is not architected, zero is one legal choice
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ff  <= evq_pkg::idx_rst;
      ovf_ff <= 1'b0;
    end else if (prod_wr_en) begin
      wr_ff  <= pwdata[evq_pkg::idx_w-1:0];
      ovf_ff <= pwdata[evq_pkg::flag_bit];
    end else begin
      if (inc_fire) wr_ff <= wr_inc;
      // a pending overflow masks further reports until acknowledged
      if (drop_full && (ovf_ff == ack_flag_ff)) ovf_ff <= !ovf_ff;
    end
  end

  // checks
  logic in_idle_blocked;
  assign in_idle_blocked = (st_ff == evq_pkg::st_idle) && fifo_out_valid && rec_stall && blocked;

  a_ovf_cause: assert property (@(posedge core_clk) disable iff (rst)
    !prod_wr_en && (ovf_ff != $past(ovf_ff)) && !$past(prod_wr_en)
      |-> $past(drop_full) && ($past(ovf_ff) == $past(ack_flag_ff)))
    else $error("overflow flag changed without enabled full drop");

  a_ovf_held: assert property (@(posedge core_clk) disable iff (rst)
    (ovf_ff != ack_flag_ff) && !prod_wr_en && !(wr_setup && hit_cons) |=> $stable(ovf_ff))
    else $error("overflow flag moved while unacknowledged");

  a_ovf_disabled: assert property (@(posedge core_clk) disable iff (rst)
    !en_ff && !prod_wr_en |=> $stable(ovf_ff))
    else $error("overflow flag moved while queue disabled");

  a_stall_kept: assert property (@(posedge core_clk) disable iff (rst)
    in_idle_blocked |=> fifo_out_valid && (fifo_out == $past(fifo_out)))
    else $error("stall record was dropped");

  a_slot_match: assert property (@(posedge core_clk) disable iff (rst)
    accept |=> mem_wr_valid
      && (mem_wr_index == $past(wr_ff[evq_pkg::idx_w-2:0] & idx_mask[evq_pkg::idx_w-2:0])))
    else $error("record slot differs from write index");

  a_read_masked: assert property (@(posedge core_clk) disable iff (rst)
    setup && !pwrite && hit_prod && !prod_wr_en
      |=> (prdata[evq_pkg::idx_w-1:0] & ~$past(field_mask)) == '0)
    else $error("bits above wrap flag read non-zero");

  a_wrap_flip: assert property (@(posedge core_clk) disable iff (rst)
    inc_fire && ((wr_ff & idx_mask) == idx_mask) && !(wr_setup && hit_ctrl)
      |=> (wrap_now != $past(wrap_now)) && ((wr_ff & idx_mask) == '0))
    else $error("index rollover did not toggle wrap flag");

  a_guard_hold: assert property (@(posedge core_clk) disable iff (rst)
    prod_wr_req && (en_ff || en_ack_ff) && !inc_fire && !drop_full |=> $stable(wr_ff))
    else $error("guarded producer register accepted a write");

  a_full_stops: assert property (@(posedge core_clk) disable iff (rst)
    q_full && (st_ff == evq_pkg::st_idle) |=> (st_ff == evq_pkg::st_idle))
    else $error("record written into a full queue");

  // the write field only moves on a landed slot write or a software load
  a_wr_idle_hold: assert property (@(posedge core_clk) disable iff (rst)
    !inc_fire && !prod_wr_en |=> $stable(wr_ff))
    else $error("write field moved without a slot write");

  // an enabled full drop with the flags equal must be reported
  a_ovf_toggle: assert property (@(posedge core_clk) disable iff (rst)
    drop_full && (ovf_ff == ack_flag_ff) |=> (ovf_ff != $past(ovf_ff)))
    else $error("overflow not reported on full drop");

  // a stall record is only taken off the head when it can be written
  a_stall_taken: assert property (@(posedge core_clk) disable iff (rst)
    fifo_pop && rec_stall |-> en_ff && !q_full)
    else $error("stall record popped into a blocked queue");

  // slot and record stand until the memory takes them
  a_slot_stable: assert property (@(posedge core_clk) disable iff (rst)
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_index) && $stable(mem_wr_data))
    else $error("pending slot write changed before acceptance");

  // acknowledge follows the enable so the producer guard closes in time
  a_en_ack_follows: assert property (@(posedge core_clk) disable iff (rst)
    en_ff |=> en_ack_ff)
    else $error("enable acknowledge lagged the enable");

  c_overflow: cover property (@(posedge core_clk) disable iff (rst)
    drop_full && (ovf_ff == ack_flag_ff));
  c_wrap: cover property (@(posedge core_clk) disable iff (rst)
    inc_fire && ((wr_ff & idx_mask) == idx_mask));
  c_stall_wait: cover property (@(posedge core_clk) disable iff (rst)
    in_idle_blocked [*3]);
  c_fifo_full: cover property (@(posedge core_clk) disable iff (rst)
    ev_valid && !ev_ready);
  c_disabled_drop: cover property (@(posedge core_clk) disable iff (rst)
    drop_off);

endmodule : event_queue_producer_index

// ==== evq_pkg.sv ====
package evq_pkg;

  // register byte offsets
  localparam logic [11:0] prod_off      = 12'h0a8;
  localparam logic [11:0] cons_off      = 12'h0ac;
  localparam logic [11:0] ctrl_off      = 12'h020;
  localparam logic [11:0] ack_off       = 12'h024;

  // field positions and widths
  localparam int          idx_w         = 20;
  localparam int          flag_bit      = 31;
  localparam int          qs_w          = 5;
  localparam int          qs_lsb        = 8;
  localparam int          en_bit        = 0;
  localparam int          full_bit      = 1;
  localparam int          empty_bit     = 2;
  localparam int          ovf_pend_bit  = 3;
  localparam logic [4:0]  qs_max        = 5'h13;

  // record path
  localparam int          rec_w         = 32;
  localparam int          fifo_depth    = 8;

  // values after reset
  localparam logic [19:0] idx_rst       = 20'h0;
  localparam logic [4:0]  qs_rst        = 5'h0;

  typedef enum logic [0:0] {
    st_idle  = 1'b0,
    st_write = 1'b1
  } wr_state_e;

endpackage : evq_pkg

// ==== rec_fifo.sv ====
`timescale 1ns/1ps
// synchronous fifo, one word in and one word out per cycle at most
module rec_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wptr_ff;
  logic [AW:0]      rptr_ff;
  logic             push;
  logic             pop;

  // extra pointer bit separates full from empty
  assign in_ready  = !((wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]));
  assign out_valid = (wptr_ff != rptr_ff);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rptr_ff[AW-1:0]];

  // storage has no reset, only the pointers matter
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wptr_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) wptr_ff <= wptr_ff + 1'b1;
      if (pop) rptr_ff <= rptr_ff + 1'b1;
    end
  end

endmodule : rec_fifo

// ==== mem_sink.sv ====
`timescale 1ns/1ps
// queue memory stand-in: takes one slot write after a chosen number of idle cycles
module mem_sink (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      mem_wr_valid,
  input  wire logic [evq_pkg::idx_w-2:0] mem_wr_index,
  input  wire logic [evq_pkg::rec_w-1:0] mem_wr_data,
  input  wire logic [3:0]                delay,
  output logic                           mem_wr_ready,
  output logic      [evq_pkg::idx_w-2:0] last_index,
  output logic      [evq_pkg::rec_w-1:0] last_data,
  output logic      [7:0]                wr_cnt
);
  logic [3:0] wait_ff;

  // ready only rises for a pending write, so an idle high ready never hides a late valid
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_wr_ready <= 1'b0;
      wait_ff      <= 4'h0;
      last_index   <= '0;
      last_data    <= '0;
      wr_cnt       <= 8'h0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      mem_wr_ready <= 1'b0;
      wait_ff      <= 4'h0;
      last_index   <= mem_wr_index;
      last_data    <= mem_wr_data;
      wr_cnt       <= wr_cnt + 8'h1;
    end else if (mem_wr_valid) begin
      if (wait_ff == delay) begin
        mem_wr_ready <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : mem_sink

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic r;} row_s;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        ev_valid, ev_ready, ev_stall, mem_wr_valid, mem_wr_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ev_data, mem_wr_data, last_data;
  logic [18:0] mem_wr_index, last_index;
  logic [7:0]  wr_cnt;
  logic [3:0]  delay;
  int          error_cnt, n_compared, cyc;
  // register cases, the last two at an unmapped address; writes only check the error response
  row_s rows [11] = '{
    '{1'b0, evq_pkg::prod_off, 32'h0, 32'h0, 1'b0},
    '{1'b1, evq_pkg::ctrl_off, 32'h300, 32'h0, 1'b0},
    '{1'b1, evq_pkg::prod_off, 32'h5, 32'h0, 1'b0},
    '{1'b0, evq_pkg::prod_off, 32'h0, 32'h5, 1'b0},
    '{1'b1, evq_pkg::prod_off, 32'hff, 32'h0, 1'b0},
    '{1'b0, evq_pkg::prod_off, 32'h0, 32'hf, 1'b0},
    '{1'b1, evq_pkg::ctrl_off, 32'h200, 32'h0, 1'b0},
    '{1'b0, evq_pkg::prod_off, 32'h0, 32'h7, 1'b0},
    '{1'b0, evq_pkg::ctrl_off, 32'h0, 32'h200, 1'b0},
    '{1'b0, 12'h100, 32'h0, 32'h0, 1'b1},
    '{1'b1, 12'h100, 32'h1, 32'h0, 1'b1}};

  event_queue_producer_index event_queue_producer_index_inst (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ev_valid(ev_valid),
    .ev_ready(ev_ready), .ev_data(ev_data), .ev_stall(ev_stall), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_index(mem_wr_index), .mem_wr_data(mem_wr_data));
  mem_sink mem_sink_inst (.core_clk(core_clk), .rst(rst), .mem_wr_valid(mem_wr_valid),
    .mem_wr_index(mem_wr_index), .mem_wr_data(mem_wr_data), .delay(delay),
    .mem_wr_ready(mem_wr_ready), .last_index(last_index), .last_data(last_data),
    .wr_cnt(wr_cnt));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask : rd_chk

  // offer one record, then leave room for the slot write or the drop to settle
  task automatic send_ev(input logic s);
    @(posedge core_clk);
    ev_valid <= 1'b1;
    ev_stall <= s;
    ev_data  <= ev_data + 32'h1;
    @(posedge core_clk);
    while (ev_ready !== 1'b1) @(posedge core_clk);
    ev_valid <= 1'b0;
    repeat (14) @(posedge core_clk);
  endtask : send_ev

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    logic [31:0] q;
    logic        e;
    {rst, psel, penable, pwrite, ev_valid, ev_stall} = 6'h20;
    {paddr, pwdata, ev_data, delay} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, q, e);
      chk({31'h0, e}, {31'h0, rows[i].r});
      if (!rows[i].w) chk(q, rows[i].e);
    end
    $display("register table done");
    wr(evq_pkg::prod_off, 32'h3);
    wr(evq_pkg::cons_off, 32'h3);
    wr(evq_pkg::ctrl_off, 32'h201);
    wr(evq_pkg::prod_off, 32'h1);
    rd_chk(evq_pkg::prod_off, 32'h3);
    send_ev(1'b0);
    chk(32'(last_index), 32'h3);
    chk(last_data, 32'h1);
    rd_chk(evq_pkg::prod_off, 32'h4);
    repeat (3) send_ev(1'b0);
    chk(32'(last_index), 32'h2);
    chk(last_data, 32'h4);
    rd_chk(evq_pkg::prod_off, 32'h7);
    rd_chk(evq_pkg::ack_off, 32'h3);
    $display("fill and wrap done");
    send_ev(1'b0);
    rd_chk(evq_pkg::prod_off, 32'h80000007);
    rd_chk(evq_pkg::ack_off, 32'hb);
    send_ev(1'b0);
    rd_chk(evq_pkg::prod_off, 32'h80000007);
    wr(evq_pkg::cons_off, 32'h80000003);
    rd_chk(evq_pkg::ack_off, 32'h3);
    send_ev(1'b0);
    rd_chk(evq_pkg::prod_off, 32'h7);
    chk(32'(wr_cnt), 32'h4);
    $display("overflow done");
    delay <= 4'h2;
    send_ev(1'b1);
    rd_chk(evq_pkg::prod_off, 32'h7);
    wr(evq_pkg::cons_off, 32'h4);
    repeat (14) @(posedge core_clk);
    rd_chk(evq_pkg::prod_off, 32'h0);
    chk(32'(wr_cnt), 32'h5);
    chk(last_data, 32'h8);
    $display("stall record done");
    wr(evq_pkg::ctrl_off, 32'h200);
    send_ev(1'b0);
    rd_chk(evq_pkg::prod_off, 32'h0);
    chk(32'(wr_cnt), 32'h5);
    chk(last_data, 32'h8);
    $display("disabled drop done");
    wr(evq_pkg::ctrl_off, 32'h0);
    wr(evq_pkg::prod_off, 32'h0);
    wr(evq_pkg::cons_off, 32'h0);
    wr(evq_pkg::ctrl_off, 32'h1);
    send_ev(1'b0);
    chk(32'(last_index), 32'h0);
    chk(last_data, 32'ha);
    rd_chk(evq_pkg::prod_off, 32'h1);
    $display("single entry done");
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(evq_pkg::prod_off, 32'h0);
    rd_chk(evq_pkg::ctrl_off, 32'h0);
    $display("mid-run reset done");
    print_verdict();
  end
endmodule : testbench
